/* logic/spio_pkg.sv */
// package: register map, reset values and widths for the shared io port
package spio_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_W = 16;
  localparam logic [ADDR_W-1:0] OFF_DIR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ODC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ANA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CNEN = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PU = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PD = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_CNFLAG = 8'h20;
  localparam logic [PORT_W-1:0] RST_DIR = 16'hffff;
  localparam logic [PORT_W-1:0] RST_ANA = 16'hffff;
  localparam logic [PORT_W-1:0] RST_ZERO = 16'h0000;
endpackage

/* logic/spio_port.sv */
// module: shared parallel io port with change notification and apb registers
`timescale 1ns/1ps
module spio_port #(
  parameter int unsigned WIDTH = spio_pkg::PORT_W,
  parameter logic [spio_pkg::PORT_W-1:0] IMPL_MASK = 16'hffff
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] weak_pullup_en,
  output logic [WIDTH-1:0] weak_pulldown_en,
  // sharing peripherals
  input wire logic [WIDTH-1:0] periph_en,
  input wire logic [WIDTH-1:0] periph_oe,
  input wire logic [WIDTH-1:0] periph_out,
  output logic [WIDTH-1:0] periph_in,
  output logic [WIDTH-1:0] analog_level,
  // change notification
  output logic change_notification_irq
);
  logic [WIDTH-1:0] dir_r, lat_r, odc_r, ana_r, cnen_r, pu_r, pd_r, flag_r;
  logic [WIDTH-1:0] sync1_r, sync2_r, prev_r;
  logic [WIDTH-1:0] impl, change_of_state, port_drive, periph_own, pin_view;
  logic wr_en, rd_setup;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [spio_pkg::ADDR_W-1:0] a);
    if (a == spio_pkg::OFF_DIR) mapped = 1'b1;
    else if (a == spio_pkg::OFF_LAT) mapped = 1'b1;
    else if (a == spio_pkg::OFF_PIN) mapped = 1'b1;
    else if (a == spio_pkg::OFF_ODC) mapped = 1'b1;
    else if (a == spio_pkg::OFF_ANA) mapped = 1'b1;
    else if (a == spio_pkg::OFF_CNEN) mapped = 1'b1;
    else if (a == spio_pkg::OFF_PU) mapped = 1'b1;
    else if (a == spio_pkg::OFF_PD) mapped = 1'b1;
    else if (a == spio_pkg::OFF_CNFLAG) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  assign impl = IMPL_MASK[WIDTH-1:0];
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable;
  // peripheral owns the pad only while enabled and driving; idle ones leave it to the port
  assign periph_own = periph_en & periph_oe;
  // analog inputs are blanked so the buffer value never leaks into reads
  assign pin_view = sync2_r & ~(ana_r & dir_r) & impl;
  assign port_drive = ~dir_r & ~periph_own & impl;
  assign change_of_state = (sync2_r ^ prev_r) & cnen_r & impl;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= spio_pkg::RST_DIR[WIDTH-1:0];
      lat_r <= spio_pkg::RST_ZERO[WIDTH-1:0];
      odc_r <= spio_pkg::RST_ZERO[WIDTH-1:0];
      ana_r <= spio_pkg::RST_ANA[WIDTH-1:0];
      cnen_r <= spio_pkg::RST_ZERO[WIDTH-1:0];
      pu_r <= spio_pkg::RST_ZERO[WIDTH-1:0];
      pd_r <= spio_pkg::RST_ZERO[WIDTH-1:0];
    end else if (wr_en) begin
      if (paddr == spio_pkg::OFF_DIR) begin
        dir_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_LAT || paddr == spio_pkg::OFF_PIN) begin
        lat_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_ODC) begin
        odc_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_ANA) begin
        ana_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_CNEN) begin
        cnen_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_PU) begin
        pu_r <= pwdata[WIDTH-1:0];
      end else if (paddr == spio_pkg::OFF_PD) begin
        pd_r <= pwdata[WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // change flags: write one to clear, a new change wins over the clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
      change_notification_irq <= 1'b0;
    end else begin
      if (wr_en && paddr == spio_pkg::OFF_CNFLAG) begin
        flag_r <= (flag_r & ~pwdata[WIDTH-1:0]) | change_of_state;
      end else begin
        flag_r <= flag_r | change_of_state;
      end
      change_notification_irq <= |(flag_r | change_of_state);
    end
  end

  // ----------------------------------------------------------------
  // pad and peripheral outputs, registered
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      periph_in <= '0;
      analog_level <= '0;
      weak_pullup_en <= '0;
      weak_pulldown_en <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (periph_own[i] && impl[i]) begin
          pin_out[i] <= periph_out[i];
          pin_oe[i] <= 1'b1;
        end else if (odc_r[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe[i] <= port_drive[i] & ~lat_r[i];
        end else begin
          pin_out[i] <= lat_r[i];
          pin_oe[i] <= port_drive[i];
        end
      end
      // the pad value seen by the peripheral is masked while the port drives it
      periph_in <= sync2_r & ~port_drive;
      analog_level <= lat_r & ana_r & ~dir_r & impl;
      weak_pullup_en <= pu_r & impl;
      weak_pulldown_en <= pd_r & impl;
    end
  end

  // ----------------------------------------------------------------
  // apb read path: data captured in setup, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        pslverr <= !mapped(paddr);
        prdata <= '0;
        if (!pwrite) begin
          if (paddr == spio_pkg::OFF_DIR) begin
            prdata[WIDTH-1:0] <= dir_r & impl;
          end else if (paddr == spio_pkg::OFF_LAT) begin
            prdata[WIDTH-1:0] <= lat_r & impl;
          end else if (paddr == spio_pkg::OFF_PIN) begin
            prdata[WIDTH-1:0] <= pin_view;
          end else if (paddr == spio_pkg::OFF_ODC) begin
            prdata[WIDTH-1:0] <= odc_r;
          end else if (paddr == spio_pkg::OFF_ANA) begin
            prdata[WIDTH-1:0] <= ana_r;
          end else if (paddr == spio_pkg::OFF_CNEN) begin
            prdata[WIDTH-1:0] <= cnen_r;
          end else if (paddr == spio_pkg::OFF_PU) begin
            prdata[WIDTH-1:0] <= pu_r;
          end else if (paddr == spio_pkg::OFF_PD) begin
            prdata[WIDTH-1:0] <= pd_r;
          end else if (paddr == spio_pkg::OFF_CNFLAG) begin
            prdata[WIDTH-1:0] <= flag_r;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  periph_drive_a: assert property (
    periph_own[0] && impl[0] |=> pin_oe[0] && pin_out[0] == $past(periph_out[0]))
    else $error("peripheral did not take the pad");
  port_drive_a: assert property (
    !periph_own[0] && !dir_r[0] && !odc_r[0] && impl[0] |=> pin_oe[0] && pin_out[0] == $past(lat_r[0]))
    else $error("port did not drive its output pin");
  no_loop_a: assert property (port_drive[0] |=> !periph_in[0])
    else $error("port output looped into peripheral input");
  input_dir_a: assert property (dir_r[0] && !periph_own[0] |=> !pin_oe[0])
    else $error("input pin is driven");
  reset_dir_a: assert property (
    $rose(presetn) |-> dir_r == spio_pkg::RST_DIR[WIDTH-1:0] && ana_r == spio_pkg::RST_ANA[WIDTH-1:0])
    else $error("reset direction or analog value wrong");
  pin_read_a: assert property (
    psel && !penable && !pwrite && paddr == spio_pkg::OFF_PIN |=> prdata[WIDTH-1:0] == $past(pin_view))
    else $error("pin read returned wrong value");
  analog_zero_a: assert property (ana_r[0] && dir_r[0] |-> !pin_view[0])
    else $error("analog input read nonzero");
  open_drain_a: assert property (odc_r[0] && !periph_own[0] |=> !pin_out[0])
    else $error("open drain pin drove high");
  flag_set_a: assert property (change_of_state[0] |=> flag_r[0] ##1 change_notification_irq)
    else $error("change flag not set or irq missing");
  flag_hold_a: assert property (
    flag_r[0] && !(wr_en && paddr == spio_pkg::OFF_CNFLAG) |=> flag_r[0])
    else $error("change flag lost without clear");
  lat_read_a: assert property (
    psel && !penable && !pwrite && paddr == spio_pkg::OFF_LAT |=> prdata[WIDTH-1:0] == $past(lat_r & impl))
    else $error("latch read returned wrong value");
  dir_read_a: assert property (
    psel && !penable && !pwrite && paddr == spio_pkg::OFF_DIR |=> prdata[WIDTH-1:0] == $past(dir_r & impl))
    else $error("direction read returned wrong value");
  lat_write_a: assert property (
    wr_en && (paddr == spio_pkg::OFF_LAT || paddr == spio_pkg::OFF_PIN) |=> lat_r == $past(pwdata[WIDTH-1:0]))
    else $error("latch write lost");
  unimpl_off_a: assert property ((pin_oe & ~impl) == '0)
    else $error("unimplemented pin is driven");
  analog_out_a: assert property (
    ana_r[0] && !dir_r[0] && impl[0] |=> analog_level[0] == $past(lat_r[0]))
    else $error("analog level does not follow the output latch");
  pull_copy_a: assert property (
    1'b1 |=> weak_pullup_en == $past(pu_r & impl) && weak_pulldown_en == $past(pd_r & impl))
    else $error("weak pull enables do not follow their registers");
  cn_gate_a: assert property (!cnen_r[0] && !flag_r[0] |=> !flag_r[0])
    else $error("change flag set on a disabled pin");
  irq_level_a: assert property ((flag_r != '0) |=> change_notification_irq)
    else $error("interrupt low while a change flag is set");
  set_wins_a: assert property (
    change_of_state[0] && wr_en && paddr == spio_pkg::OFF_CNFLAG && pwdata[0] |=> flag_r[0])
    else $error("clear beat a new change");
  flag_clear_a: assert property (
    !change_of_state[0] && wr_en && paddr == spio_pkg::OFF_CNFLAG && pwdata[0] |=> !flag_r[0])
    else $error("change flag not cleared");
  hi_zero_a: assert property (psel && !penable |=> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  unmapped_a: assert property (psel && !penable && !mapped(paddr) |=> pslverr)
    else $error("unmapped access without error");
  ready_up_a: assert property (!$rose(presetn) |-> pready)
    else $error("bus not ready after reset");

  // every pin, not just bit zero, must obey the ownership mux
  for (genvar g = 0; g < WIDTH; g++) begin : g_pin_chk
    own_pin_a: assert property (
      periph_own[g] && impl[g] |=> pin_oe[g] && pin_out[g] == $past(periph_out[g]))
      else $error("peripheral lost a pad");
    idle_pin_a: assert property (
      periph_en[g] && !periph_oe[g] && !dir_r[g] && !odc_r[g] && impl[g]
      |=> pin_oe[g] && pin_out[g] == $past(lat_r[g]))
      else $error("idle peripheral blocked the port");
    in_pin_a: assert property (dir_r[g] && !periph_own[g] |=> !pin_oe[g])
      else $error("input pin driven");
    od_pin_a: assert property (
      odc_r[g] && !periph_own[g] |=> !pin_out[g] && pin_oe[g] == $past(!dir_r[g] && !lat_r[g] && impl[g]))
      else $error("open drain pin drove high");
    loop_pin_a: assert property (port_drive[g] |=> !periph_in[g])
      else $error("port output looped back");
  end

  write_cov: cover property (wr_en && paddr == spio_pkg::OFF_LAT);
  change_cov: cover property (change_of_state != '0 ##2 change_notification_irq);
  share_cov: cover property (periph_own[0] ##1 !periph_own[0]);
  od_cov: cover property (odc_r[0] && !dir_r[0] && !lat_r[0] && pin_oe[0]);
  pin_read_cov: cover property (psel && penable && !pwrite && paddr == spio_pkg::OFF_PIN);
endmodule

/* verif/spio_pad_model.sv */
// pad model: resolves each pin from port driver, external driver and weak pulls
`timescale 1ns/1ps
module spio_pad_model (
  // clock
  input wire logic pclk,
  // port side
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pu_en,
  input wire logic [15:0] pd_en,
  // external driver
  input wire logic [15:0] ext_oe,
  input wire logic [15:0] ext_val,
  // pad level
  output logic [15:0] pin_in
);
  // ------------------------------
  // pad resolution
  // ------------------------------
  logic [15:0] float_r = 16'h5a5a;
  // an undriven pad wanders so nothing can lean on a stale level
  always @(posedge pclk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pu_en[i]) pin_in[i] = 1'b1;
      else if (pd_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = float_r[i];
    end
  end
endmodule

/* verif/tb_top.sv */
// testbench: apb-driven checks of the shared io port against a behavioural model
`timescale 1ns/1ps
module tb_top;
  // bit 15 left unimplemented to see it read as zero
  localparam logic [15:0] MASK = 16'h7fff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, er;
  logic [15:0] pin_in, pin_out, pin_oe, pu, pd, p_in, a_lvl, t1, t2;
  logic [15:0] p_en = 16'h0, p_oe = 16'h0, p_out = 16'h0, ext_oe = 16'hffff, ext_val = 16'h0;
  logic [15:0] m_dir = 16'hffff, m_lat = 16'h0, m_ana = 16'hffff, own = 16'h0;
  int bad_count = 0;
  int samples_checked = 0;
  spio_port #(.IMPL_MASK(MASK)) i_spio_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .weak_pullup_en(pu), .weak_pulldown_en(pd),
    .periph_en(p_en), .periph_oe(p_oe), .periph_out(p_out), .periph_in(p_in), .analog_level(a_lvl),
    .change_notification_irq(irq));
  spio_pad_model i_spio_pad_model (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pu_en(pu), .pd_en(pd),
    .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));
  initial forever #5 pclk = ~pclk;
  // ------------------------------
  // bus and compare helpers
  // ------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave asks; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
    apb(1'b0, a, 16'h0);
    chk(rd[15:0], exp, what);
  endtask
  function automatic logic [15:0] pad();
    return (own & p_out) | (~own & ~m_dir & m_lat) | (~own & m_dir & ext_val);
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    // the tests need well under a thousand cycles
    wt(5000);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end
  // ------------------------------
  // stimulus
  // ------------------------------
  initial begin
    t1 = 16'($urandom(32'hfd3f));
    wt(10);
    presetn <= 1'b1;
    rdchk(spio_pkg::OFF_DIR, MASK, "dir rst");
    apb(1'b0, spio_pkg::OFF_ANA, 16'h0);
    chk(rd[15:0] & MASK, MASK, "ana rst");
    rdchk(spio_pkg::OFF_LAT, 16'h0, "lat rst");
    chk(pin_oe, 16'h0, "oe rst");
    $display("test reset done");
    m_ana = 16'h0;
    apb(1'b1, spio_pkg::OFF_ANA, m_ana);
    m_dir = 16'hff00;
    apb(1'b1, spio_pkg::OFF_DIR, m_dir);
    m_lat = 16'($urandom);
    apb(1'b1, spio_pkg::OFF_LAT, m_lat);
    ext_val <= 16'($urandom);
    wt(4);
    chk(pin_oe, ~m_dir & MASK, "oe");
    chk(pin_out & ~m_dir & MASK, m_lat & ~m_dir & MASK, "out");
    rdchk(spio_pkg::OFF_LAT, m_lat & MASK, "lat");
    rdchk(spio_pkg::OFF_PIN, pad() & MASK, "pin");
    m_lat = 16'($urandom);
    apb(1'b1, spio_pkg::OFF_PIN, m_lat);
    wt(4);
    rdchk(spio_pkg::OFF_LAT, m_lat & MASK, "pin wr");
    $display("test port done");
    p_en <= 16'($urandom);
    p_oe <= 16'($urandom);
    p_out <= 16'($urandom);
    // pad moves one edge later, then two sync edges and the registered periph_in
    wt(6);
    own = p_en & p_oe;
    chk(pin_oe, (own | ~m_dir) & MASK, "own oe");
    chk(pin_out & pin_oe, pad() & pin_oe, "own out");
    chk(p_in & MASK, ((own & p_out) | (~own & m_dir & ext_val)) & MASK, "p_in");
    rdchk(spio_pkg::OFF_PIN, pad() & MASK, "own pin");
    p_en <= 16'h0;
    own = 16'h0;
    apb(1'b1, spio_pkg::OFF_ODC, 16'hffff);
    wt(4);
    chk(pin_oe, ~m_lat & ~m_dir & MASK, "od oe");
    chk(pin_out & pin_oe, 16'h0, "od out");
    apb(1'b1, spio_pkg::OFF_ODC, 16'h0);
    m_ana = 16'hffff;
    apb(1'b1, spio_pkg::OFF_ANA, m_ana);
    m_dir = 16'h0ff0;
    apb(1'b1, spio_pkg::OFF_DIR, m_dir);
    wt(4);
    chk(a_lvl & MASK, m_lat & ~m_dir & MASK, "alvl");
    rdchk(spio_pkg::OFF_PIN, pad() & ~m_dir & MASK, "ana pin");
    $display("test share done");
    m_ana = 16'h0;
    apb(1'b1, spio_pkg::OFF_ANA, m_ana);
    m_dir = 16'hffff;
    apb(1'b1, spio_pkg::OFF_DIR, m_dir);
    t1 = 16'($urandom);
    t2 = 16'($urandom);
    apb(1'b1, spio_pkg::OFF_PU, t1);
    apb(1'b1, spio_pkg::OFF_PD, t2);
    // pull outputs are registered one edge behind their registers
    wt(2);
    chk(pu, t1 & MASK, "pu");
    chk(pd, t2 & MASK, "pd");
    // release the outside drivers: pulled pins settle, the others float
    ext_oe <= 16'h0;
    wt(4);
    apb(1'b0, spio_pkg::OFF_PIN, 16'h0);
    chk(rd[15:0] & (t1 | t2) & MASK, t1 & MASK, "pulls");
    ext_oe <= 16'hffff;
    apb(1'b1, spio_pkg::OFF_CNEN, 16'h0005);
    wt(4);
    apb(1'b1, spio_pkg::OFF_CNFLAG, 16'hffff);
    ext_val <= ext_val ^ 16'h0002;
    wt(6);
    chk({15'h0, irq}, 16'h0, "cn off");
    ext_val <= ext_val ^ 16'h0001;
    wt(6);
    chk({15'h0, irq}, 16'h1, "cn irq");
    wt(20);
    rdchk(spio_pkg::OFF_CNFLAG, 16'h0001, "flag");
    apb(1'b1, spio_pkg::OFF_CNFLAG, 16'h0001);
    wt(2);
    chk({15'h0, irq}, 16'h0, "cn clr");
    $display("test notify done");
    apb(1'b1, spio_pkg::OFF_PU, 16'h0);
    apb(1'b1, spio_pkg::OFF_PD, 16'h0);
    m_dir = 16'hfffe;
    apb(1'b1, spio_pkg::OFF_DIR, m_dir);
    apb(1'b0, 8'h40, 16'h0);
    chk({15'h0, er}, 16'h1, "unmapped");
    apb(1'b1, 8'h40, 16'h1234);
    rdchk(spio_pkg::OFF_DIR, m_dir & MASK, "dir kept");
    $display("test unmapped done");
    report_and_stop;
  end
endmodule
